// ===== design/otdg_pkg.sv
// Purpose: shared constants for the overtravel direction gate
// Assumes: 32-bit AHB-Lite register slave, one clock at 200 MHz
// Notes:   offsets are byte addresses
package otdg_pkg;
  localparam logic [7:0]  OTDG_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  OTDG_STOP_OFS   = 8'h04;
  localparam logic [7:0]  OTDG_ESTQ_OFS   = 8'h08;
  localparam logic [7:0]  OTDG_STAT_OFS   = 8'h0C;
  localparam logic [7:0]  OTDG_IRQS_OFS   = 8'h10;
  localparam logic [7:0]  OTDG_IRQM_OFS   = 8'h14;
  localparam logic [7:0]  OTDG_APPLY_OFS  = 8'h18;
  // ctrl fields
  localparam int          OTDG_DIR_BIT    = 0;
  localparam int          OTDG_FSRC_LSB   = 4;
  localparam int          OTDG_RSRC_LSB   = 8;
  localparam logic [3:0]  OTDG_SRC_INPUT_F = 4'h1;
  localparam logic [3:0]  OTDG_SRC_INPUT_R = 4'h2;
  localparam logic [3:0]  OTDG_SRC_IGNORE  = 4'h8;
  localparam logic [7:0]  OTDG_STOP_RST   = 8'h00;
  localparam logic [9:0]  OTDG_ESTQ_RST   = 10'd800;
  localparam logic [9:0]  OTDG_ESTQ_MAX   = 10'd800;
  // stop method low digit and second digit
  localparam logic [3:0]  OTDG_STOP_DB    = 4'h0;
  localparam logic [3:0]  OTDG_STOP_DB1   = 4'h1;
  localparam logic [3:0]  OTDG_STOP_COAST = 4'h2;
  localparam logic [3:0]  OTDG_DEC_ZCLAMP = 4'h1;
  localparam logic [3:0]  OTDG_DEC_COAST  = 4'h2;
  // interrupt bits
  localparam int          OTDG_EV_FOT     = 0;
  localparam int          OTDG_EV_ROT     = 1;
  localparam int          OTDG_EV_STOP    = 2;
  localparam int          OTDG_NEV        = 3;
  // axis states
  typedef enum logic [2:0] {
    OTDG_RUN, OTDG_DBRAKE, OTDG_COAST, OTDG_DECEL, OTDG_ZCLAMP, OTDG_BBLOCK
  } otdg_state_t;
endpackage

// ===== design/otdg_sync.sv
// Purpose: three-stage input synchroniser, change taken once stages two and three agree
// Assumes: input is asynchronous to clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module otdg_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic dout_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r   <= RST_VAL;
      s2_r   <= RST_VAL;
      s3_r   <= RST_VAL;
      dout_r <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout_r <= s3_r;
      end
    end
  end
  assign dout = dout_r;
endmodule

// ===== design/otdg_ahb.sv
// Purpose: AHB-Lite slave front end, zero wait states, always OKAY
// Assumes: single word transfers
// Notes:   write data presented one cycle after the address phase
`timescale 1ns/1ps
module otdg_ahb (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic             rd_en,
  output logic [7:0]       rd_addr
);
  logic       wpend_r;
  logic [7:0] waddr_r;
  wire        take = hsel && hready && htrans[1];
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wpend_r <= 1'b0;
      waddr_r <= 8'h00;
    end else begin
      wpend_r <= take && hwrite;
      if (take) begin
        waddr_r <= haddr[7:0];
      end
    end
  end
  assign wr_en   = wpend_r;
  assign wr_addr = waddr_r;
  assign rd_en   = take && !hwrite;
  assign rd_addr = haddr[7:0];
endmodule

// ===== design/otdg_top.sv
// Purpose: overtravel direction gate between limit switches, host reference and motor loop
// Assumes: 200 MHz clk, synchronous active-low reset, AHB-Lite registers
// Notes:   limit inputs high means travel allowed
`timescale 1ns/1ps
module otdg_top
  import otdg_pkg::*;
#(
  parameter int REF_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire logic [31:0]             hwdata,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    fwd_limit_in,
  input  wire logic                    rev_limit_in,
  input  wire logic signed [REF_W-1:0] ref_in,
  input  wire logic                    motor_stopped,
  input  wire logic                    enc_a_in,
  input  wire logic                    enc_b_in,
  output logic signed [REF_W-1:0]      ref_out,
  output logic                         dynamic_brake,
  output logic                         base_block,
  output logic                         zero_clamp,
  output logic                         decel_active,
  output logic      [9:0]              torque_limit,
  output logic                         fwd_overtravel,
  output logic                         rev_overtravel,
  output logic                         encoder_phase_a_out,
  output logic                         encoder_phase_b_out,
  output logic                         irq
);
  import otdg_pkg::*;

  otdg_state_t st_r;
  otdg_state_t st_nxt;
  logic [11:0] ctrl_r;
  logic [11:0] ctrl_act_r;
  logic [7:0]  stop_r;
  logic [7:0]  stop_act_r;
  logic [9:0]  estq_r;
  logic [OTDG_NEV-1:0] irqs_r;
  logic [OTDG_NEV-1:0] irqm_r;
  logic        fot_prev_r;
  logic        rot_prev_r;
  logic [31:0] hrdata_r;
  logic signed [REF_W-1:0] ref_r;
  logic        db_r;
  logic        bb_r;
  logic        zc_r;
  logic        dec_r;
  logic [9:0]  tq_r;
  logic        fot_r;
  logic        rot_r;
  logic        pa_r;
  logic        pb_r;
  logic        irq_r;
  logic        fwd_sync;
  logic        rev_sync;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic        enc_a_s;
  logic        enc_b_s;

  // limit synchronisers
  // limits reset to travel allowed, so no false overtravel edge follows reset
  otdg_sync #(.RST_VAL(1'b1)) u_fsync (
    .clk    (clk),
    .resetn (resetn),
    .din    (fwd_limit_in),
    .dout   (fwd_sync)
  );
  otdg_sync #(.RST_VAL(1'b1)) u_rsync (
    .clk    (clk),
    .resetn (resetn),
    .din    (rev_limit_in),
    .dout   (rev_sync)
  );
  // encoder phases, same filter as the limits
  otdg_sync #(.RST_VAL(1'b0)) u_async (
    .clk    (clk),
    .resetn (resetn),
    .din    (enc_a_in),
    .dout   (enc_a_s)
  );
  otdg_sync #(.RST_VAL(1'b0)) u_bsync (
    .clk    (clk),
    .resetn (resetn),
    .din    (enc_b_in),
    .dout   (enc_b_s)
  );

  otdg_ahb u_ahb (
    .clk     (clk),
    .resetn  (resetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .rd_en   (rd_en),
    .rd_addr (rd_addr)
  );

  // active settings, latched only by the apply (restart) register
  wire       dir_cw  = ctrl_act_r[OTDG_DIR_BIT];
  wire [3:0] fsrc    = ctrl_act_r[OTDG_FSRC_LSB +: 4];
  wire [3:0] rsrc    = ctrl_act_r[OTDG_RSRC_LSB +: 4];
  wire [3:0] sm_lo   = stop_act_r[3:0];
  wire [3:0] sm_hi   = stop_act_r[7:4];

  wire fwd_ok  = (fsrc == OTDG_SRC_IGNORE) ? 1'b1 : fwd_sync;
  wire rev_ok  = (rsrc == OTDG_SRC_IGNORE) ? 1'b1 : rev_sync;
  wire fot     = !fwd_ok;
  wire rot     = !rev_ok;
  wire ref_fwd = (ref_in > 0);
  wire ref_rev = (ref_in < 0);
  // motion away from the limit passes
  wire blocked = (fot && ref_fwd) || (rot && ref_rev);
  wire ev_fot  = fot && !fot_prev_r;
  wire ev_rot  = rot && !rot_prev_r;
  wire trip    = ev_fot || ev_rot;
  wire use_dec = (sm_hi == OTDG_DEC_ZCLAMP) || (sm_hi == OTDG_DEC_COAST);
  wire use_db  = (sm_lo == OTDG_STOP_DB) || (sm_lo == OTDG_STOP_DB1);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      OTDG_RUN: begin
        if (blocked && (trip || !motor_stopped)) begin
          if (use_dec) begin
            st_nxt = OTDG_DECEL;
          end else if (use_db) begin
            st_nxt = OTDG_DBRAKE;
          end else begin
            st_nxt = OTDG_COAST;
          end
        end
      end
      OTDG_DBRAKE, OTDG_COAST: begin
        if (motor_stopped) begin
          st_nxt = OTDG_BBLOCK;
        end
      end
      OTDG_DECEL: begin
        if (motor_stopped) begin
          st_nxt = (sm_hi == OTDG_DEC_ZCLAMP) ? OTDG_ZCLAMP : OTDG_BBLOCK;
        end
      end
      OTDG_ZCLAMP, OTDG_BBLOCK: begin
        if (!blocked) begin
          st_nxt = OTDG_RUN;
        end
      end
    endcase
  end

  wire run_now = (st_nxt == OTDG_RUN);
  // reference toward an active limit is held at zero
  wire pass_ref = run_now && !blocked;
  // direction select only flips polarity toward the motor
  wire signed [REF_W-1:0] ref_dir = dir_cw ? -ref_in : ref_in;
  wire at_hold = (st_nxt == OTDG_BBLOCK) || (st_nxt == OTDG_ZCLAMP);
  wire ev_stop = (st_r != OTDG_RUN) && (st_r != st_nxt) && at_hold;
  wire [OTDG_NEV-1:0] ev = {ev_stop, ev_rot, ev_fot};
  // write-one-clear of the status bits
  wire [OTDG_NEV-1:0] w1c = (wr_en && wr_addr == OTDG_IRQS_OFS) ?
                            hwdata[OTDG_NEV-1:0] : '0;
  wire [OTDG_NEV-1:0] irqs_nxt = (irqs_r & ~w1c) | ev;
  // writes above the maximum clamp to it
  wire [9:0] estq_w = (hwdata[9:0] > OTDG_ESTQ_MAX) ? OTDG_ESTQ_MAX : hwdata[9:0];

  // read mux, unmapped offsets read zero
  wire [31:0] rd_mux =
      (rd_addr == OTDG_CTRL_OFS)  ? {20'h0, ctrl_r} :
      (rd_addr == OTDG_STOP_OFS)  ? {24'h0, stop_r} :
      (rd_addr == OTDG_ESTQ_OFS)  ? {22'h0, estq_r} :
      (rd_addr == OTDG_STAT_OFS)  ? {25'h0, st_r, rev_sync, fwd_sync, rot, fot} :
      (rd_addr == OTDG_IRQS_OFS)  ? {29'h0, irqs_r} :
      (rd_addr == OTDG_IRQM_OFS)  ? {29'h0, irqm_r} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r       <= OTDG_RUN;
      ctrl_r     <= {OTDG_SRC_INPUT_R, OTDG_SRC_INPUT_F, 4'h0};
      ctrl_act_r <= {OTDG_SRC_INPUT_R, OTDG_SRC_INPUT_F, 4'h0};
      stop_r     <= OTDG_STOP_RST;
      stop_act_r <= OTDG_STOP_RST;
      estq_r     <= OTDG_ESTQ_RST;
      irqs_r     <= '0;
      irqm_r     <= '0;
      fot_prev_r <= 1'b0;
      rot_prev_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      fot_prev_r <= fot;
      rot_prev_r <= rot;
      // set wins over write-one-clear
      irqs_r     <= irqs_nxt;
      if (wr_en && wr_addr == OTDG_CTRL_OFS) begin
        ctrl_r <= hwdata[11:0];
      end
      if (wr_en && wr_addr == OTDG_STOP_OFS) begin
        stop_r <= hwdata[7:0];
      end
      if (wr_en && wr_addr == OTDG_ESTQ_OFS) begin
        estq_r <= estq_w;
      end
      if (wr_en && wr_addr == OTDG_IRQM_OFS) begin
        irqm_r <= hwdata[OTDG_NEV-1:0];
      end
      if (wr_en && wr_addr == OTDG_APPLY_OFS && hwdata[0]) begin
        ctrl_act_r <= ctrl_r;
        stop_act_r <= stop_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hrdata_r <= 32'h00000000;
      ref_r    <= '0;
      db_r     <= 1'b0;
      bb_r     <= 1'b0;
      zc_r     <= 1'b0;
      dec_r    <= 1'b0;
      tq_r     <= OTDG_ESTQ_RST;
      fot_r    <= 1'b0;
      rot_r    <= 1'b0;
      pa_r     <= 1'b0;
      pb_r     <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      if (rd_en) begin
        hrdata_r <= rd_mux;
      end
      ref_r <= pass_ref ? ref_dir : '0;
      db_r  <= (st_nxt == OTDG_DBRAKE);
      bb_r  <= (st_nxt == OTDG_BBLOCK) || (st_nxt == OTDG_COAST);
      zc_r  <= (st_nxt == OTDG_ZCLAMP);
      dec_r <= (st_nxt == OTDG_DECEL);
      tq_r  <= estq_r;
      fot_r <= fot;
      rot_r <= rot;
      pa_r  <= enc_a_s;
      pb_r  <= enc_b_s;
      irq_r <= |(irqs_nxt & irqm_r);
    end
  end

  assign hrdata              = hrdata_r;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign ref_out             = ref_r;
  assign dynamic_brake       = db_r;
  assign base_block          = bb_r;
  assign zero_clamp          = zc_r;
  assign decel_active        = dec_r;
  assign torque_limit        = tq_r;
  assign fwd_overtravel      = fot_r;
  assign rev_overtravel      = rot_r;
  assign encoder_phase_a_out = pa_r;
  assign encoder_phase_b_out = pb_r;
  assign irq                 = irq_r;
endmodule

// ===== test/otdg_assertions.sv
// Purpose: port-level checks on the overtravel direction gate
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to otdg_top, sees only its ports
`timescale 1ns/1ps
module otdg_assertions #(
  parameter int REF_W = 16
) (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    fwd_limit_in,
  input wire logic                    rev_limit_in,
  input wire logic                    enc_a_in,
  input wire logic                    enc_b_in,
  input wire logic signed [REF_W-1:0] ref_out,
  input wire logic                    dynamic_brake,
  input wire logic                    base_block,
  input wire logic                    zero_clamp,
  input wire logic                    decel_active,
  input wire logic [9:0]              torque_limit,
  input wire logic                    fwd_overtravel,
  input wire logic                    rev_overtravel,
  input wire logic                    encoder_phase_a_out,
  input wire logic                    encoder_phase_b_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence fwd_clear;
    fwd_limit_in && $stable(fwd_limit_in);
  endsequence
  sequence rev_clear;
    rev_limit_in && $stable(rev_limit_in);
  endsequence
  sequence both_flagged;
    (fwd_overtravel && rev_overtravel) [*2];
  endsequence
  AST_FWD_CLEAR: assert property (fwd_clear [*8] |-> !fwd_overtravel)
    else $error("forward flag set with limit input on");
  AST_REV_CLEAR: assert property (rev_clear [*8] |-> !rev_overtravel)
    else $error("reverse flag set with limit input on");
  AST_BOTH_BLOCK: assert property (both_flagged |-> ref_out == 0)
    else $error("motion passed with both limits active");
  AST_ENC_A: assert property ($stable(enc_a_in) [*8] |-> encoder_phase_a_out == enc_a_in)
    else $error("phase a output polarity differs from input");
  AST_ENC_B: assert property ($stable(enc_b_in) [*8] |-> encoder_phase_b_out == enc_b_in)
    else $error("phase b output polarity differs from input");
  AST_TQ_MAX: assert property (torque_limit <= 10'h320)
    else $error("torque limit above 800 percent");
  AST_ZC_AFTER_DECEL: assert property ($rose(zero_clamp) |-> $past(decel_active))
    else $error("zero clamp entered without deceleration");
  AST_STOP_EXCL: assert property ($onehot0({zero_clamp, base_block, decel_active}))
    else $error("more than one stop state output active");
  AST_STOP_NOREF: assert property ((decel_active || dynamic_brake) [*2] |-> ref_out == 0)
    else $error("reference passed during stop");
endmodule

bind otdg_top otdg_assertions #(.REF_W(REF_W)) u_chk (
  .clk(clk), .resetn(resetn), .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
  .enc_a_in(enc_a_in), .enc_b_in(enc_b_in), .ref_out(ref_out),
  .dynamic_brake(dynamic_brake), .base_block(base_block), .zero_clamp(zero_clamp),
  .decel_active(decel_active), .torque_limit(torque_limit),
  .fwd_overtravel(fwd_overtravel), .rev_overtravel(rev_overtravel),
  .encoder_phase_a_out(encoder_phase_a_out), .encoder_phase_b_out(encoder_phase_b_out));

// ===== test/otdg_limits.sv
// Purpose: limit switches and motor loop beside the gate
// Assumes: trip requests come from the bench
// Notes:   motor counts as stopped after 8 cycles of zero reference
`timescale 1ns/1ps
module otdg_limits #(
  parameter int REF_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    fwd_trip,
  input  wire logic                    rev_trip,
  input  wire logic signed [REF_W-1:0] ref_out,
  output logic                         fwd_limit_in,
  output logic                         rev_limit_in,
  output logic                         motor_stopped
);
  logic [3:0] idle_r = 4'h0;
  assign fwd_limit_in = !fwd_trip;
  assign rev_limit_in = !rev_trip;
  always_ff @(posedge clk) begin
    if (ref_out != 0)
      idle_r <= 4'h0;
    else if (idle_r != 4'h8)
      idle_r <= idle_r + 4'h1;
  end
  assign motor_stopped = (idle_r == 4'h8);
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench for the overtravel direction gate
// Assumes: zero-wait AHB-Lite slave, 200 MHz clock
// Notes:   one task per scenario
`timescale 1ns/1ps
module testbench;
  import otdg_pkg::*;
  localparam int REF_W = 16;
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic fwd_trip = 1'b0, rev_trip = 1'b0, enc_a = 1'b0, enc_b = 1'b0;
  logic signed [REF_W-1:0] ref_in = '0;
  wire logic signed [REF_W-1:0] ref_out;
  wire logic [31:0] hrdata;
  wire logic [9:0] torque_limit;
  wire logic hreadyout, hresp, fl, rl, mstop, dynamic_brake, base_block, zero_clamp;
  wire logic decel_active, fwd_overtravel, rev_overtravel, pa, pb, irq;
  int fail_count = 0, n_tests = 0, cyc = 0;
  otdg_top #(.REF_W(REF_W)) uut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fwd_limit_in(fl),
    .rev_limit_in(rl), .ref_in(ref_in), .motor_stopped(mstop), .enc_a_in(enc_a),
    .enc_b_in(enc_b), .ref_out(ref_out), .dynamic_brake(dynamic_brake),
    .base_block(base_block), .zero_clamp(zero_clamp), .decel_active(decel_active),
    .torque_limit(torque_limit), .fwd_overtravel(fwd_overtravel),
    .rev_overtravel(rev_overtravel), .encoder_phase_a_out(pa),
    .encoder_phase_b_out(pb), .irq(irq));
  otdg_limits #(.REF_W(REF_W)) u_lim (.clk(clk), .fwd_trip(fwd_trip), .rev_trip(rev_trip),
    .ref_out(ref_out), .fwd_limit_in(fl), .rev_limit_in(rl), .motor_stopped(mstop));
  always #2.5 clk = ~clk;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic t_regs;
    logic [7:0] adr [4] = '{OTDG_CTRL_OFS, OTDG_STOP_OFS, OTDG_ESTQ_OFS, 8'h1C};
    logic [31:0] val [4] = '{32'h210, 32'h0, 32'h320, 32'h0};
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, adr[i], 32'h0);
      chk(q, val[i]);
    end
    bus(1'b1, OTDG_ESTQ_OFS, 32'h384);
    bus(1'b0, OTDG_ESTQ_OFS, 32'h0);
    chk(q, 32'h320);
    bus(1'b1, OTDG_ESTQ_OFS, 32'h12C);
    bus(1'b0, OTDG_ESTQ_OFS, 32'h0);
    chk(q, 32'h12C);
    chk(32'({hreadyout, hresp}), 32'h2);
    bus(1'b1, OTDG_IRQM_OFS, 32'h7);
    $display("regs done");
  endtask
  task automatic t_dir;
    ref_in <= 16'sd100;
    enc_a <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(ref_out), 32'(16'sd100));
    bus(1'b1, OTDG_CTRL_OFS, 32'h211);
    bus(1'b1, OTDG_APPLY_OFS, 32'h1);
    repeat (4) @(posedge clk);
    chk(32'(ref_out), 32'(-16'sd100));
    chk(32'({pa, pb}), 32'h2);
    bus(1'b1, OTDG_CTRL_OFS, 32'h210);
    bus(1'b1, OTDG_APPLY_OFS, 32'h1);
    ref_in <= 16'sd0;
    repeat (12) @(posedge clk);
    $display("dir done");
  endtask
  task automatic t_stop(input logic [7:0] code, input logic [2:0] during,
                        input logic [1:0] after);
    bus(1'b1, OTDG_STOP_OFS, {24'h0, code});
    bus(1'b1, OTDG_APPLY_OFS, 32'h1);
    ref_in <= 16'sd100;
    repeat (12) @(posedge clk);
    fwd_trip <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(32'(fwd_overtravel), 32'h0);
    for (int i = 0; i < 40 && fwd_overtravel !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(32'(fwd_overtravel), 32'h1);
    chk(32'({dynamic_brake, decel_active, base_block}), 32'(during));
    chk(32'(ref_out), 32'h0);
    chk(32'(torque_limit), 32'h12C);
    for (int i = 0; i < 60 && (mstop !== 1'b1 || decel_active || dynamic_brake); i++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    chk(32'({base_block, zero_clamp}), 32'(after));
    chk(32'(irq), 32'h1);
    bus(1'b0, OTDG_IRQS_OFS, 32'h0);
    chk(q, 32'h5);
    bus(1'b1, OTDG_IRQS_OFS, 32'h7);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    ref_in <= -16'sd100;
    for (int i = 0; i < 40 && ref_out !== -16'sd100; i++) @(posedge clk);
    chk(32'(ref_out), 32'(-16'sd100));
    fwd_trip <= 1'b0;
    ref_in <= 16'sd0;
    repeat (12) @(posedge clk);
    $display("stop %h done", code);
  endtask
  task automatic t_ignore;
    bus(1'b1, OTDG_IRQM_OFS, 32'h0);
    bus(1'b1, OTDG_CTRL_OFS, 32'h880);
    fwd_trip <= 1'b1;
    rev_trip <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'({fwd_overtravel, rev_overtravel}), 32'h3);
    chk(32'(irq), 32'h0);
    ref_in <= -16'sd100;
    repeat (3) @(posedge clk);
    chk(32'(ref_out), 32'h0);
    bus(1'b1, OTDG_APPLY_OFS, 32'h1);
    ref_in <= 16'sd100;
    repeat (8) @(posedge clk);
    chk(32'(fwd_overtravel), 32'h0);
    chk(32'(rev_overtravel), 32'h0);
    chk(32'(ref_out), 32'(16'sd100));
    fwd_trip <= 1'b0;
    rev_trip <= 1'b0;
    ref_in <= 16'sd0;
    bus(1'b1, OTDG_IRQS_OFS, 32'h7);
    $display("ignore done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_dir;
    t_stop(8'h00, 3'b100, 2'b10);
    t_stop(8'h01, 3'b100, 2'b10);
    t_stop(8'h02, 3'b001, 2'b10);
    // zero clamp hold for loaded axes
    t_stop(8'h10, 3'b010, 2'b01);
    t_stop(8'h20, 3'b010, 2'b10);
    t_ignore;
    complete_run;
  end
endmodule
